// file: hw/psu_params.svh
`ifndef PSU_PARAMS_SVH
`define PSU_PARAMS_SVH
// ---------------------------------------------
// clock and timing
// ---------------------------------------------
`define CLK_PERIOD_NS 32'h0000_0014
`define OV_DEBOUNCE_NS 32'h0000_3E80
`define UV_DEBOUNCE_NS 32'h0006_DDD0
`define RESTART_PERIOD_NS 32'h3B9A_CA00
`define SS_STEP_NS 32'h0000_2710
`define SS_STEPS 7'h7F
// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define TRIM_OFS 8'h08
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define CTRL_AUTO_BIT 0
`define CTRL_CLEAR_BIT 1
// ---------------------------------------------
// reset values
// ---------------------------------------------
`define CTRL_RST 1'b0
`define TRIM_LOAD_OV_RST 8'h80
`define TRIM_LOCAL_OV_RST 8'hA0
`define TRIM_LOCAL_UV_RST 8'h60
`define TRIM_CLAMP_RST 8'h68
`endif

// file: hw/psu_pkg.sv
package psu_pkg;
    typedef enum logic [2:0]
    {
        ST_OFF = 3'b000,
        ST_RAMP = 3'b001,
        ST_ON = 3'b010,
        ST_WAIT = 3'b011,
        ST_LATCH = 3'b100
    } psu_state_t;

    typedef struct packed
    {
        logic [7:0] clamp;
        logic [7:0] local_uv;
        logic [7:0] local_ov;
        logic [7:0] load_ov;
    } trim_t;

    typedef struct packed
    {
        logic gnd_open;
        logic internal_reference_ov;
        logic external_reference_uv;
        logic vdd_above_upper;
        logic vdd_ov;
        logic load_ov;
        logic local_ov;
        logic local_uv;
    } cmp_t;
endpackage

// file: hw/psu_housekeeping_fault_supervisor.sv
// Notes on behaviour
// - gate drive only while pulse good
// - low line: line good false, output good true
// - soft-start ramps reference in 127 steps
// - supply overvoltage latches off at once, no load overvoltage needed
// - supply lockout acts as local undervoltage
// - auto-restart every second, undervoltage only
// - reference monitors feed overvoltage and undervoltage
// - ground open latches off like overvoltage
// - reference buffer waits for upper lockout level
// - supply good needs all five conditions
// - ground above sense negative drops supply good
// - load overvoltage drops gate, not latching
// - local overvoltage only after load overvoltage
// - overcurrent fault disables false undervoltage clamp
// - thresholds programmable by host over bus
// - debounce overvoltage 16us, undervoltage 450us
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "psu_params.svh"

// ---------------------------------------------
// debounce filter
// ---------------------------------------------
module psu_debounce #(
    parameter int CYCLES = 800
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_raw,
    output logic o_filt
);
    localparam int CW = $clog2(CYCLES + 1);
    typedef struct packed
    {
        logic filt;
        logic [CW-1:0] cnt;
    } deb_t;
    deb_t state_ff;
    deb_t nxt_state;

    always_comb
    begin
        nxt_state = state_ff;
        if (i_raw == state_ff.filt)
        begin
            nxt_state.cnt = '0;
        end
        else if (state_ff.cnt == CW'(CYCLES - 1))
        begin
            nxt_state.filt = i_raw;
            nxt_state.cnt = '0;
        end
        else
        begin
            nxt_state.cnt = state_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign o_filt = state_ff.filt;
endmodule // psu_debounce

// ---------------------------------------------
// supervisor top
// ---------------------------------------------
module psu_housekeeping_fault_supervisor #(
    parameter int UV_DEBOUNCE_CYCLES =
        (`UV_DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int RESTART_CYCLES = `RESTART_PERIOD_NS / `CLK_PERIOD_NS
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire psu_pkg::cmp_t i_cmp,
    input wire logic i_pulse_good,
    input wire logic i_ac_low,
    input wire logic i_overcurrent_fault,
    output logic o_isolation_gate_en,
    output logic o_line_power_good,
    output logic o_output_power_good,
    output logic o_converter_en,
    output logic [6:0] o_soft_start_ref,
    output logic o_ref_buffer_en,
    output logic o_supply_good,
    output logic o_false_uv_clamp_en,
    output psu_pkg::trim_t o_trim
);
    import psu_pkg::*;

    localparam int OV_CYCLES = (`OV_DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int SS_CYCLES = (`SS_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int SS_W = $clog2(SS_CYCLES + 1);
    localparam int RS_W = $clog2(RESTART_CYCLES + 1);

    typedef struct packed
    {
        psu_state_t st;
        logic [6:0] ss_ref;
        logic [SS_W-1:0] step_cnt;
        logic [RS_W-1:0] rst_cnt;
        logic latched;
        logic load_seen;
        logic ref_buf;
        logic auto_rs;
        trim_t trim;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } top_t;

    top_t state_ff;
    top_t nxt_state;
    logic [4:0] ov_raw;
    logic [4:0] ov_db;
    logic [2:0] uv_raw;
    logic [2:0] uv_db;
    logic addr_ok;
    logic clr;
    logic latch_fault;
    logic uv_fault;
    logic blank;
    logic step_tick;

    // ---------------------------------------------
    // comparator debounce
    // ---------------------------------------------
    // reference monitors join fault groups
    assign ov_raw = {i_cmp.gnd_open, i_cmp.internal_reference_ov, i_cmp.vdd_ov, i_cmp.local_ov, i_cmp.load_ov};
    assign uv_raw = {i_cmp.external_reference_uv, ~i_cmp.vdd_above_upper, i_cmp.local_uv};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_ov
            psu_debounce #(.CYCLES(OV_CYCLES)) u_deb (
                .i_clk_sys(i_clk_sys),
                .i_rst_n(i_rst_n),
                .i_raw(ov_raw[gi]),
                .o_filt(ov_db[gi])
            );
        end
        for (gi = 0; gi < 3; gi++)
        begin : g_uv
            psu_debounce #(.CYCLES(UV_DEBOUNCE_CYCLES)) u_deb (
                .i_clk_sys(i_clk_sys),
                .i_rst_n(i_rst_n),
                .i_raw(uv_raw[gi]),
                .o_filt(uv_db[gi])
            );
        end
    endgenerate

    // ---------------------------------------------
    // fault decode
    // ---------------------------------------------
    // five supply conditions
    assign o_supply_good = ~i_cmp.gnd_open & ~i_cmp.internal_reference_ov & ~i_cmp.external_reference_uv
        & i_cmp.vdd_above_upper & ~i_cmp.vdd_ov;
    assign latch_fault = (ov_db[1] & (state_ff.load_seen | ov_db[0])) | ov_db[2]
        | ov_db[3] | ov_db[4];
    assign blank = (state_ff.st == ST_RAMP) | i_ac_low;
    assign uv_fault = |uv_db & ~blank;
    assign step_tick = state_ff.step_cnt == SS_W'(SS_CYCLES - 1);
    assign addr_ok = i_hsel & i_htrans[1] & i_hready;
    assign clr = state_ff.wr_pend & (state_ff.wr_addr == `CTRL_OFS) & i_hwdata[`CTRL_CLEAR_BIT];

    // ---------------------------------------------
    // next state
    // ---------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.step_cnt = step_tick ? '0 : state_ff.step_cnt + 1'b1;
        // buffer enable sticks once level seen
        nxt_state.ref_buf = state_ff.ref_buf | i_cmp.vdd_above_upper;
        if (state_ff.st == ST_OFF)
        begin
            nxt_state.load_seen = 1'b0;
        end
        else if (ov_db[0])
        begin
            nxt_state.load_seen = 1'b1;
        end
        nxt_state.latched = latch_fault | (state_ff.latched & ~clr);
        case (state_ff.st)
            ST_OFF:
            begin
                if (o_supply_good & ~state_ff.latched & ~latch_fault)
                begin
                    nxt_state.st = ST_RAMP;
                    nxt_state.ss_ref = '0;
                    nxt_state.step_cnt = '0;
                end
            end
            ST_RAMP, ST_ON:
            begin
                if (latch_fault)
                begin
                    nxt_state.st = ST_LATCH;
                end
                else if (uv_fault)
                begin
                    nxt_state.st = state_ff.auto_rs ? ST_WAIT : ST_LATCH;
                    nxt_state.latched = ~state_ff.auto_rs | state_ff.latched;
                    nxt_state.rst_cnt = '0;
                end
                else if (state_ff.st == ST_RAMP && step_tick)
                begin
                    if (state_ff.ss_ref == `SS_STEPS)
                    begin
                        nxt_state.st = ST_ON;
                    end
                    else
                    begin
                        nxt_state.ss_ref = state_ff.ss_ref + 1'b1;
                    end
                end
            end
            ST_WAIT:
            begin
                nxt_state.rst_cnt = state_ff.rst_cnt + 1'b1;
                if (latch_fault)
                begin
                    nxt_state.st = ST_LATCH;
                end
                else if (state_ff.rst_cnt == RS_W'(RESTART_CYCLES - 1))
                begin
                    nxt_state.st = o_supply_good ? ST_RAMP : ST_OFF;
                    nxt_state.ss_ref = '0;
                    nxt_state.step_cnt = '0;
                end
            end
            ST_LATCH:
            begin
                if (~state_ff.latched)
                begin
                    nxt_state.st = ST_OFF;
                end
            end
            default:
            begin
                nxt_state.st = ST_OFF;
            end
        endcase
        if (state_ff.st != ST_RAMP && state_ff.st != ST_ON && state_ff.st != ST_OFF)
        begin
            nxt_state.ss_ref = '0;
        end
        nxt_state.wr_pend = addr_ok & i_hwrite;
        nxt_state.wr_addr = i_haddr[7:0];
        if (state_ff.wr_pend && state_ff.wr_addr == `CTRL_OFS)
        begin
            nxt_state.auto_rs = i_hwdata[`CTRL_AUTO_BIT];
        end
        if (state_ff.wr_pend && state_ff.wr_addr == `TRIM_OFS)
        begin
            nxt_state.trim = i_hwdata;
        end
        nxt_state.rdata = 32'h0000_0000;
        if (addr_ok && !i_hwrite)
        begin
            if (i_haddr[7:0] == `CTRL_OFS)
            begin
                nxt_state.rdata = {31'h0000_0000, state_ff.auto_rs};
            end
            else if (i_haddr[7:0] == `STATUS_OFS)
            begin
                nxt_state.rdata = {16'h0000, state_ff.ss_ref, 2'b00, o_supply_good,
                    state_ff.ref_buf, state_ff.load_seen, state_ff.latched, state_ff.st};
            end
            else if (i_haddr[7:0] == `TRIM_OFS)
            begin
                nxt_state.rdata = state_ff.trim;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_ff <= '0;
            state_ff.auto_rs <= `CTRL_RST;
            state_ff.trim <= {`TRIM_CLAMP_RST, `TRIM_LOCAL_UV_RST, `TRIM_LOCAL_OV_RST,
                `TRIM_LOAD_OV_RST};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ---------------------------------------------
    // outputs
    // ---------------------------------------------
    // pulse good gates transistor
    assign o_isolation_gate_en = (state_ff.st == ST_ON) & i_pulse_good & ~ov_db[0];
    assign o_line_power_good = (state_ff.st == ST_ON) & ~i_ac_low;
    assign o_output_power_good = state_ff.st == ST_ON;
    assign o_converter_en = (state_ff.st == ST_RAMP) | (state_ff.st == ST_ON);
    assign o_soft_start_ref = state_ff.ss_ref;
    assign o_ref_buffer_en = state_ff.ref_buf;
    assign o_false_uv_clamp_en = ~i_overcurrent_fault;
    assign o_trim = state_ff.trim;
    assign o_hrdata = state_ff.rdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence ramp_full_s;
        state_ff.st == ST_RAMP && state_ff.ss_ref == `SS_STEPS && step_tick;
    endsequence
    gate_pulse_a: assert property (o_isolation_gate_en |-> i_pulse_good)
        else $error("gate on without pulse good");
    low_line_a: assert property ((state_ff.st == ST_ON && i_ac_low)
        |-> !o_line_power_good && o_output_power_good) else $error("low line outputs wrong");
    ramp_step_a: assert property ((state_ff.st == ST_RAMP && step_tick && !latch_fault
        && !uv_fault && state_ff.ss_ref != `SS_STEPS) |=> o_soft_start_ref
        == $past(o_soft_start_ref) + 7'h01) else $error("ramp missed a step");
    ramp_done_a: assert property (ramp_full_s ##0 (!latch_fault && !uv_fault)
        |=> state_ff.st == ST_ON && o_soft_start_ref == `SS_STEPS) else $error("ramp end bad");
    vdd_ov_a: assert property ((ov_db[2] && state_ff.st inside {ST_RAMP, ST_ON})
        |=> state_ff.st == ST_LATCH ##1 state_ff.st == ST_LATCH) else $error("no ov shutdown");
    lockout_a: assert property ((uv_db[1] && !blank && state_ff.auto_rs && !latch_fault
        && state_ff.st == ST_ON) |=> state_ff.st == ST_WAIT) else $error("no uv sequence");
    restart_a: assert property ((state_ff.st == ST_WAIT && !latch_fault
        && state_ff.rst_cnt == RS_W'(RESTART_CYCLES - 1)) |=> state_ff.st inside {ST_RAMP, ST_OFF}
        && o_soft_start_ref == 7'h00) else $error("restart timing bad");
    gnd_latch_a: assert property (ov_db[4] |=> state_ff.latched)
        else $error("ground open not latched");
    gnd_drop_a: assert property (i_cmp.gnd_open |-> !o_supply_good)
        else $error("supply good with ground open");
    load_gate_a: assert property (ov_db[0] |-> !o_isolation_gate_en)
        else $error("gate on during load ov");
    ovp_gated_a: assert property ((ov_db[1] && !state_ff.load_seen && !ov_db[0] &&
        !ov_db[2] && !ov_db[3] && !ov_db[4] && !state_ff.latched) |=> !state_ff.latched)
        else $error("ovp without load ov");
    clamp_oc_a: assert property (i_overcurrent_fault |-> !o_false_uv_clamp_en)
        else $error("clamp on under overcurrent");
    latch_hold_a: assert property ((state_ff.latched && !clr) |=> state_ff.latched
        && state_ff.st != ST_RAMP) else $error("latch released");
endmodule // psu_housekeeping_fault_supervisor

// file: test/psu_sense_model.sv
`timescale 1ns/1ns
// ---------------------------------------------
// analog sense and primary side model
// ---------------------------------------------
module psu_sense_model
(
    input wire psu_pkg::cmp_t i_flt,
    input wire logic i_xfmr_bad,
    input wire logic i_line_low,
    input wire logic i_overload,
    output psu_pkg::cmp_t o_cmp,
    output logic o_pulse_good,
    output logic o_ac_low,
    output logic o_overcurrent_fault
);
    import psu_pkg::*;
    // comparator levels, a lockout request pulls vdd below the upper level
    always_comb
    begin
        o_cmp = i_flt;
        o_cmp.vdd_above_upper = !i_flt.vdd_above_upper;
    end
    assign o_pulse_good = !i_xfmr_bad;
    assign o_ac_low = i_line_low;
    assign o_overcurrent_fault = i_overload;
endmodule // psu_sense_model

// file: test/tb_psu_housekeeping_fault_supervisor.sv
`timescale 1ns/1ns
module tb_psu_housekeeping_fault_supervisor;
    import psu_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_hsel, i_hwrite, xfmr_bad, line_low, overload;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    logic o_hreadyout, o_hresp, o_isolation_gate_en, o_line_power_good, o_output_power_good;
    logic o_converter_en, o_ref_buffer_en, o_supply_good, o_false_uv_clamp_en, pulse_good;
    logic ac_low, oc_fault;
    logic [6:0] o_soft_start_ref;
    cmp_t flt, cmp;
    trim_t o_trim;
    logic [7:0] lf [3];
    int n_mismatch, n_checks, k;

    always #10 i_clk_sys = ~i_clk_sys;

    psu_sense_model model (.i_flt(flt), .i_xfmr_bad(xfmr_bad), .i_line_low(line_low),
        .i_overload(overload), .o_cmp(cmp), .o_pulse_good(pulse_good), .o_ac_low(ac_low),
        .o_overcurrent_fault(oc_fault));

    psu_housekeeping_fault_supervisor #(.UV_DEBOUNCE_CYCLES(20), .RESTART_CYCLES(50)) uut (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp), .i_cmp(cmp), .i_pulse_good(pulse_good), .i_ac_low(ac_low),
        .i_overcurrent_fault(oc_fault), .o_isolation_gate_en(o_isolation_gate_en),
        .o_line_power_good(o_line_power_good), .o_output_power_good(o_output_power_good),
        .o_converter_en(o_converter_en), .o_soft_start_ref(o_soft_start_ref),
        .o_ref_buffer_en(o_ref_buffer_en), .o_supply_good(o_supply_good),
        .o_false_uv_clamp_en(o_false_uv_clamp_en), .o_trim(o_trim));

    // ---------------------------------------------
    // checking and closing
    // ---------------------------------------------
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: pick = o_converter_en;
            1: pick = o_isolation_gate_en;
            2: pick = o_output_power_good;
            default: pick = o_hreadyout;
        endcase
    endfunction

    // bounded wait on one output, n gives the cycles spent
    task automatic wait_pick(input int sel, input logic v, input int lim, output int n);
        n = 0;
        while (pick(sel) !== v)
        begin
            @(posedge i_clk_sys);
            n++;
            if (n > lim)
            begin
                n_mismatch++;
                $display("BAD %0t wait timeout on %0d", $time, sel);
                complete_run();
            end
        end
    endtask

    // ---------------------------------------------
    // ahb-lite single word transfer
    // ---------------------------------------------
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        int n;
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_haddr <= {24'h00_0000, a};
        i_hwrite <= w;
        @(posedge i_clk_sys);
        wait_pick(4, 1'b1, 50, n);
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        @(posedge i_clk_sys);
        wait_pick(4, 1'b1, 50, n);
        r = o_hrdata;
        chk({31'h0, o_hresp}, 32'h0, "bus response");
    endtask

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial
    begin
        n_mismatch = 0;
        n_checks = 0;
        i_hsel = 1'b0;
        i_haddr = 32'h0000_0000;
        i_htrans = 2'h0;
        i_hwrite = 1'b0;
        i_hsize = 3'h2;
        i_hwdata = 32'h0000_0000;
        flt = 8'h10;
        xfmr_bad = 1'b0;
        line_low = 1'b0;
        overload = 1'b0;
        lf = '{8'h80, 8'h40, 8'h08};
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        bus(1'b0, 8'h08, 32'h0000_0000, rd);
        chk(rd, 32'h6860_A080, "trim reset");
        bus(1'b1, 8'h08, 32'h1234_5678, rd);
        bus(1'b0, 8'h08, 32'h0000_0000, rd);
        chk(rd, 32'h1234_5678, "trim readback");
        chk(o_trim, 32'h1234_5678, "trim outputs");
        bus(1'b0, 8'h0C, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000, "unmapped read");
        chk({31'h0, o_ref_buffer_en}, 32'h0, "ref buffer under lockout");
        chk({31'h0, o_supply_good}, 32'h0, "supply good under lockout");
        overload <= 1'b1;
        @(posedge i_clk_sys);
        chk({31'h0, o_false_uv_clamp_en}, 32'h0, "clamp in overcurrent");
        overload <= 1'b0;
        @(posedge i_clk_sys);
        chk({31'h0, o_false_uv_clamp_en}, 32'h1, "clamp restored");
        $display("test registers done");
        flt <= 8'h00;
        wait_pick(0, 1'b1, 40, k);
        chk({31'h0, o_ref_buffer_en}, 32'h1, "ref buffer up");
        chk({25'h0, o_soft_start_ref}, 32'h0, "ramp from zero");
        for (int i = 3; i < 8; i++)
        begin
            flt <= cmp_t'(8'h01 << i);
            @(posedge i_clk_sys);
            chk({31'h0, o_supply_good}, 32'h0, "supply good drop");
            flt <= 8'h00;
            @(posedge i_clk_sys);
            chk({31'h0, o_supply_good}, 32'h1, "supply good back");
        end
        flt <= 8'h02;
        repeat (900) @(posedge i_clk_sys);
        flt <= 8'h00;
        bus(1'b0, 8'h04, 32'h0000_0000, rd);
        chk({27'h0, rd[4:0]}, 32'h1, "local ov ignored in ramp");
        chk({25'h0, o_soft_start_ref}, 32'h1, "ramp first step");
        wait_pick(2, 1'b1, 66000, k);
        chk({25'h0, o_soft_start_ref}, 32'h7F, "ramp full scale");
        chk({31'h0, o_line_power_good}, 32'h1, "line good on");
        $display("test power up done");
        xfmr_bad <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        chk({31'h0, o_isolation_gate_en}, 32'h0, "gate without pulse good");
        xfmr_bad <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        chk({31'h0, o_isolation_gate_en}, 32'h1, "gate with pulse good");
        line_low <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        chk({30'h0, o_line_power_good, o_output_power_good}, 32'h1, "low line");
        line_low <= 1'b0;
        flt <= 8'h04;
        wait_pick(1, 1'b0, 900, k);
        chk({31'h0, k >= 800 && k <= 802}, 32'h1, "ov debounce time");
        chk({31'h0, o_output_power_good}, 32'h1, "load ov not latched");
        flt <= 8'h00;
        wait_pick(1, 1'b1, 900, k);
        $display("test on state done");
        bus(1'b1, 8'h00, 32'h0000_0001, rd);
        flt <= 8'h11;
        wait_pick(0, 1'b0, 60, k);
        bus(1'b0, 8'h04, 32'h0000_0000, rd);
        chk({29'h0, rd[2:0]}, 32'h3, "restart wait state");
        flt <= 8'h00;
        wait_pick(0, 1'b1, 80, k);
        chk({31'h0, k >= 40 && k <= 52}, 32'h1, "restart interval");
        chk({25'h0, o_soft_start_ref}, 32'h0, "ramp restarts at zero");
        $display("test auto restart done");
        for (int i = 0; i < 3; i++)
        begin
            flt <= cmp_t'(lf[i]);
            wait_pick(0, 1'b0, 900, k);
            repeat (60) @(posedge i_clk_sys);
            bus(1'b1, 8'h00, 32'h0000_0003, rd);
            bus(1'b0, 8'h04, 32'h0000_0000, rd);
            chk({27'h0, rd[4:0]}, (i == 0) ? 32'h1C : 32'h0C,
                "fault latched");
            flt <= 8'h00;
            repeat (820) @(posedge i_clk_sys);
            bus(1'b1, 8'h00, 32'h0000_0003, rd);
            wait_pick(0, 1'b1, 20, k);
        end
        $display("test latched faults done");
        complete_run();
    end
endmodule // tb_psu_housekeeping_fault_supervisor
